// ---- rtl/rpm_ctrl.sv ----
// Radio power-mode controller: APB registers, mode sequencer, regulator
// stepping, wake from full-off and power status.
// Assumes pins fifo_empty, radio_enable_line_n, supply_low, regulator_ok
// arrive asynchronously and are synchronised here.
`timescale 1ns/10ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module rpm_ctrl
#(
  parameter int SETTLE_CYC = rpm_pkg::REG_SETTLE_CYC,
  parameter int WAKE_CYC = rpm_pkg::WAKE_INIT_CYC,
  parameter int LP_HALF_CYC = rpm_pkg::LPOSC_HALF_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fifo_empty,
  input wire logic radio_enable_line_n,
  input wire logic supply_low,
  input wire logic regulator_ok,
  output logic miso_ready,
  output logic fifo_flush,
  output logic fifo_access_en,
  output logic core_supply_en,
  output logic xtal_ref_en,
  output logic ref_en,
  output logic synth_en,
  output logic synth_tx_freq,
  output logic rx_en,
  output logic tx_en,
  output logic lp_osc_clk,
  output logic [1:0] regulator_level,
  output logic irq
);
  import rpm_pkg::*;

  typedef enum logic [2:0] {
    ST_WAKE, ST_RUN, ST_WAIT_EMPTY, ST_SETTLE, ST_FULL_OFF
  } rpm_state_e;

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic fifo_empty_s;
  logic enable_n_s;
  logic supply_low_s;
  logic regulator_ok_s;
  rpm_sync #(.W(4), .INIT(4'h2)) u_sync
  (
    .pclk(pclk),
    .presetn(presetn),
    .d({regulator_ok, supply_low, radio_enable_line_n, fifo_empty}),
    .q({regulator_ok_s, supply_low_s, enable_n_s, fifo_empty_s})
  );

  // Legal mode codes; anything else is reserved
  function automatic logic mode_legal(input logic [3:0] m);
    mode_legal = (m == MODE_CORE_OFF) || (m == MODE_FULL_OFF) ||
      (m == MODE_STANDBY) || (m == MODE_FIFO_ONLY) ||
      (m == MODE_SYNTH_RX) || (m == MODE_RX_ACTIVE) ||
      (m == MODE_WOR) || (m == MODE_SYNTH_TX) ||
      (m == MODE_TX_ACTIVE);
  endfunction

  // Modes that must wait for an empty FIFO
  function automatic logic needs_empty(input logic [3:0] m);
    needs_empty = (m == MODE_CORE_OFF) || (m == MODE_STANDBY) ||
      (m == MODE_WOR);
  endfunction

  // Regulator level demanded by a mode: 0 off, 1 retain, 2 ref, 3 full
  function automatic logic [1:0] reg_level(input logic [3:0] m);
    if (m == MODE_FULL_OFF)
      reg_level = 2'h0;
    else if ((m == MODE_CORE_OFF) || (m == MODE_WOR))
      reg_level = 2'h1;
    else if ((m == MODE_STANDBY) || (m == MODE_FIFO_ONLY))
      reg_level = 2'h2;
    else
      reg_level = 2'h3;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Registers and state
  rpm_state_e state_ff, nxt_state;
  logic [3:0] mode_ff, nxt_mode;
  logic [3:0] active_ff, nxt_active;
  logic [IRQ_W-1:0] irq_stat_ff, nxt_irq_stat;
  logic [IRQ_W-1:0] irq_mask_ff, nxt_irq_mask;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic [CNT_W-1:0] lp_cnt_ff, nxt_lp_cnt;
  logic lp_clk_ff, nxt_lp_clk;
  logic [12:0] out_ff, nxt_out;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] lvl_ev;
  logic wr_acc;
  logic rd_acc;
  logic addr_ok;

  // Access phase; pready rises after one wait state in the access phase
  assign wr_acc = psel && penable && !pready_ff && pwrite;
  assign rd_acc = psel && penable && !pready_ff && !pwrite;
  assign addr_ok = (paddr == OFS_MODE) || (paddr == OFS_ACTIVE) ||
    (paddr == OFS_POWSTAT) || (paddr == OFS_IRQ_STAT) ||
    (paddr == OFS_IRQ_MASK);

  //////////////////////////////////////////////////////////////////////////
  // APB slave and software registers
  always_comb
  begin
    nxt_pready = psel && penable && !pready_ff;
    nxt_pslverr = psel && penable && !pready_ff && !addr_ok;
    nxt_prdata = 32'h0000_0000;
    nxt_mode = mode_ff;
    nxt_irq_mask = irq_mask_ff;
    if (rd_acc)
    begin
      if (paddr == OFS_MODE)
        nxt_prdata = {28'h0, mode_ff};
      else if (paddr == OFS_ACTIVE)
        nxt_prdata = {28'h0, active_ff};
      else if (paddr == OFS_POWSTAT)
        nxt_prdata = {30'h0, supply_low_s, regulator_ok_s};
      else if (paddr == OFS_IRQ_STAT)
        nxt_prdata = {28'h0, irq_stat_ff};
      else if (paddr == OFS_IRQ_MASK)
        nxt_prdata = {28'h0, irq_mask_ff};
    end
    if (wr_acc)
    begin
      // Reserved codes are dropped so the sequencer never sees them
      if ((paddr == OFS_MODE) && mode_legal(pwdata[3:0]))
        nxt_mode = pwdata[3:0];
      else if (paddr == OFS_IRQ_MASK)
        nxt_irq_mask = pwdata[IRQ_W-1:0];
    end
    // Full-off loses every register; wake restores reset values
    if (state_ff == ST_FULL_OFF)
    begin
      nxt_mode = MODE_RESET;
      nxt_irq_mask = '0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Mode sequencer
  always_comb
  begin
    nxt_state = state_ff;
    nxt_active = active_ff;
    nxt_cnt = cnt_ff;
    ev = '0;
    case (state_ff)
      ST_WAKE:
      begin
        // Hold MISO low through initialisation
        if (cnt_ff >= CNT_W'(WAKE_CYC - 1))
        begin
          nxt_state = ST_RUN;
          nxt_cnt = '0;
          ev[BIT_WAKE_DONE] = 1'b1;
        end
        else
          nxt_cnt = cnt_ff + 1'b1;
      end
      ST_RUN:
      begin
        if (mode_ff != active_ff)
        begin
          if (mode_ff == MODE_FULL_OFF)
          begin
            nxt_active = MODE_FULL_OFF;
            nxt_state = ST_FULL_OFF;
          end
          else if (needs_empty(mode_ff))
            nxt_state = ST_WAIT_EMPTY;
          else
          begin
            nxt_state = ST_SETTLE;
            nxt_cnt = '0;
          end
        end
      end
      ST_WAIT_EMPTY:
      begin
        // Host may change its mind while waiting
        if (!needs_empty(mode_ff))
          nxt_state = ST_RUN;
        else if (fifo_empty_s)
        begin
          nxt_state = ST_SETTLE;
          nxt_cnt = '0;
        end
      end
      ST_SETTLE:
      begin
        // A late change to full-off, or to a mode that needs an empty
        // FIFO while the FIFO holds data, goes back through run; else apply once the regulator stepped
        if ((mode_ff == MODE_FULL_OFF) ||
          (needs_empty(mode_ff) && !fifo_empty_s))
          nxt_state = ST_RUN;
        else if (cnt_ff >= CNT_W'(SETTLE_CYC - 1))
        begin
          nxt_active = mode_ff;
          nxt_state = ST_RUN;
          ev[BIT_MODE_DONE] = 1'b1;
        end
        else
          nxt_cnt = cnt_ff + 1'b1;
      end
      ST_FULL_OFF:
      begin
        if (!enable_n_s)
        begin
          nxt_state = ST_WAKE;
          nxt_active = MODE_RESET;
          nxt_cnt = '0;
        end
      end
      default:
        nxt_state = ST_WAKE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Sticky interrupt status, write one to clear; set wins
  always_comb
  begin
    lvl_ev = '0;
    lvl_ev[BIT_REG_READY] = regulator_ok_s;
    lvl_ev[BIT_BROWNOUT] = supply_low_s;
    nxt_irq_stat = irq_stat_ff;
    if (wr_acc && (paddr == OFS_IRQ_STAT))
      nxt_irq_stat = irq_stat_ff & ~pwdata[IRQ_W-1:0];
    // Full-off loses the status as well
    if (state_ff == ST_FULL_OFF)
      nxt_irq_stat = '0;
    nxt_irq_stat = nxt_irq_stat | ev | lvl_ev;
  end

  // 640 Hz low-power oscillator, only in wake-on-radio
  always_comb
  begin
    nxt_lp_cnt = '0;
    nxt_lp_clk = 1'b0;
    if (active_ff == MODE_WOR)
    begin
      nxt_lp_clk = lp_clk_ff;
      nxt_lp_cnt = lp_cnt_ff + 1'b1;
      if (lp_cnt_ff >= CNT_W'(LP_HALF_CYC - 1))
      begin
        nxt_lp_cnt = '0;
        nxt_lp_clk = !lp_clk_ff;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= ST_WAKE;
      mode_ff <= MODE_RESET;
      active_ff <= MODE_RESET;
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
      cnt_ff <= '0;
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      lp_cnt_ff <= '0;
      lp_clk_ff <= 1'b0;
      out_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      mode_ff <= nxt_mode;
      active_ff <= nxt_active;
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
      cnt_ff <= nxt_cnt;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      lp_cnt_ff <= nxt_lp_cnt;
      lp_clk_ff <= nxt_lp_clk;
      out_ff <= nxt_out;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Section enables decoded from the applied mode; miso first, irq last
  logic on_st;
  logic [3:0] am;
  assign on_st = (state_ff != ST_WAKE) && (state_ff != ST_FULL_OFF);
  assign am = active_ff;

  // FIFO data dropped in core-off, wake-on-radio, standby and full-off;
  // the regulator leads the mode so it is settled before sections start
  always_comb
  begin
    nxt_out = {on_st,
      !on_st || needs_empty(am),
      on_st && !needs_empty(am),
      on_st && (reg_level(am) != 2'h1),
      on_st && (am == MODE_STANDBY),
      on_st && (reg_level(am) >= 2'h2),
      on_st && (reg_level(am) == 2'h3),
      on_st && (reg_level(am) == 2'h3) && am[2],
      on_st && (am == MODE_RX_ACTIVE),
      on_st && (am == MODE_TX_ACTIVE),
      reg_level(am), |(irq_stat_ff & irq_mask_ff)};
    if (state_ff == ST_FULL_OFF)
      nxt_out[2:1] = 2'h0;
    else if (state_ff == ST_SETTLE)
      nxt_out[2:1] = reg_level(mode_ff);
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign lp_osc_clk = lp_clk_ff;
  assign {miso_ready, fifo_flush, fifo_access_en, core_supply_en,
    xtal_ref_en, ref_en, synth_en, synth_tx_freq, rx_en, tx_en,
    regulator_level, irq} = out_ff;
endmodule // rpm_ctrl
`default_nettype wire

// ---- rtl/rpm_pkg.sv ----
// Package for the radio power-mode controller.
// Assumes a single 100 MHz APB clock domain.
package rpm_pkg;
  // Mode codes
  localparam logic [3:0] MODE_CORE_OFF = 4'h0;
  localparam logic [3:0] MODE_FULL_OFF = 4'h1;
  localparam logic [3:0] MODE_STANDBY = 4'h5;
  localparam logic [3:0] MODE_FIFO_ONLY = 4'h6;
  localparam logic [3:0] MODE_SYNTH_RX = 4'h8;
  localparam logic [3:0] MODE_RX_ACTIVE = 4'h9;
  localparam logic [3:0] MODE_WOR = 4'hB;
  localparam logic [3:0] MODE_SYNTH_TX = 4'hC;
  localparam logic [3:0] MODE_TX_ACTIVE = 4'hD;
  localparam logic [3:0] MODE_RESET = 4'h0;
  // Register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_ACTIVE = 8'h04;
  localparam logic [7:0] OFS_POWSTAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  // Status and interrupt bit positions
  localparam int BIT_REG_READY = 0;
  localparam int BIT_BROWNOUT = 1;
  localparam int BIT_MODE_DONE = 2;
  localparam int BIT_WAKE_DONE = 3;
  localparam int IRQ_W = 4;
  // Timing: regulator settle and wake-up init, in ns
  localparam int REG_SETTLE_NS = 1000;
  localparam int CLK_NS = 10;
  localparam int REG_SETTLE_CYC = (REG_SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_INIT_NS = 2000;
  localparam int WAKE_INIT_CYC = (WAKE_INIT_NS + CLK_NS - 1) / CLK_NS;
  // Low-power oscillator, 640 Hz
  localparam int LPOSC_HZ = 640;
  localparam int CLK_HZ = 100000000;
  localparam int LPOSC_HALF_CYC = CLK_HZ / (2 * LPOSC_HZ);
  localparam int CNT_W = 20;
endpackage : rpm_pkg

// ---- rtl/rpm_sync.sv ----
// Two-flop synchroniser for asynchronous level inputs.
// Assumes the destination clock is pclk.
`timescale 1ns/10ps
`default_nettype none
module rpm_sync
#(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;
  // First stage feeds only the second
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_ff <= INIT;
      q_ff <= INIT;
    end
    else
    begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end
  assign q = q_ff;
endmodule // rpm_sync
`default_nettype wire

// ---- test/rpm_ctrl_properties.sv ----
// Port-level checks for the radio power-mode controller.
// Assumes one pclk domain and asynchronous active-low presetn.
`timescale 1ns/10ps
`default_nettype none
module rpm_ctrl_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic miso_ready,
  input wire logic fifo_flush,
  input wire logic fifo_access_en,
  input wire logic synth_en,
  input wire logic synth_tx_freq,
  input wire logic rx_en,
  input wire logic tx_en,
  input wire logic lp_osc_clk,
  input wire logic [1:0] regulator_level
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////////////////////////////
  // Bus timing: exactly one wait state, answer stands one cycle
  wait_state_a: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response without pready or with data");
  unmapped_a: assert property (
    psel && penable && !pready && paddr > 8'h10 |=> pslverr)
    else $error("unmapped address not refused");
  //////////////////////////////////////////////////////////////////////////
  // Section enables stay consistent with one defined mode
  tx_synth_a: assert property (
    tx_en |-> synth_en && synth_tx_freq && !rx_en)
    else $error("transmitter on without transmit synthesizer");
  rx_synth_a: assert property (
    rx_en |-> synth_en && !synth_tx_freq && !tx_en)
    else $error("receiver on without receive synthesizer");
  wor_osc_a: assert property (
    lp_osc_clk |-> fifo_flush && !synth_en && !fifo_access_en)
    else $error("low-power clock outside wake-on-radio");
  fifo_keep_a: assert property (fifo_access_en |-> !fifo_flush)
    else $error("FIFO flushed while accessible");
  wake_quiet_a: assert property (!miso_ready |-> !synth_en && !rx_en)
    else $error("radio sections on before device ready");
  // Regulator is already stepped up when a radio path starts
  reg_first_a: assert property (
    $rose(rx_en) || $rose(tx_en) |-> regulator_level == 2'h3)
    else $error("radio path on before full regulator level");
  cover property (pslverr);
  cover property ($rose(tx_en));
  cover property ($rose(lp_osc_clk));
endmodule // rpm_ctrl_properties
bind rpm_ctrl rpm_ctrl_properties chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .miso_ready(miso_ready),
  .fifo_flush(fifo_flush), .fifo_access_en(fifo_access_en),
  .synth_en(synth_en), .synth_tx_freq(synth_tx_freq), .rx_en(rx_en),
  .tx_en(tx_en), .lp_osc_clk(lp_osc_clk),
  .regulator_level(regulator_level));
`default_nettype wire

// ---- test/rpm_radio_model.sv ----
// Model of the transceiver surroundings: data FIFO and supplies.
// Assumes push and pop pulses from the bench, one word each.
`timescale 1ns/10ps
`default_nettype none
module rpm_radio_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic push,
  input wire logic pop,
  input wire logic brown,
  input wire logic fifo_flush,
  input wire logic [1:0] regulator_level,
  output logic fifo_empty,
  output logic regulator_ok,
  output logic supply_low
);
  logic [7:0] cnt_ff;
  logic [1:0] lvl_ff;
  // FIFO fill; flush drops everything held
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cnt_ff <= 8'h00;
    else if (fifo_flush)
      cnt_ff <= 8'h00;
    else
      cnt_ff <= cnt_ff + {7'h0, push} - {7'h0, pop && cnt_ff != 8'h0};
  assign fifo_empty = cnt_ff == 8'h00;
  // Regulator dips a cycle on every level change, like a real settle
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      lvl_ff <= 2'h0;
      regulator_ok <= 1'b0;
    end
    else
    begin
      lvl_ff <= regulator_level;
      regulator_ok <= lvl_ff == regulator_level && regulator_level != 2'h0;
    end
  assign supply_low = brown;
endmodule // rpm_radio_model
`default_nettype wire

// ---- test/test_rpm_ctrl.sv ----
// Self-checking bench for the radio power-mode controller.
// Assumes short settle and wake counts to keep the run brief.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  mismatches++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module test_rpm_ctrl;
  import rpm_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic en_n, push, pop, brown, f_empty, reg_ok, s_low, miso, flush;
  logic fifo_acc, core_en, xtal, refe, synth, txf, rx, tx, lp, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [1:0] lvl;
  int mismatches, cmp_count;
  rpm_ctrl #(.SETTLE_CYC(4), .WAKE_CYC(4), .LP_HALF_CYC(8)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fifo_empty(f_empty),
    .radio_enable_line_n(en_n), .supply_low(s_low), .regulator_ok(reg_ok),
    .miso_ready(miso), .fifo_flush(flush), .fifo_access_en(fifo_acc),
    .core_supply_en(core_en), .xtal_ref_en(xtal), .ref_en(refe),
    .synth_en(synth), .synth_tx_freq(txf), .rx_en(rx), .tx_en(tx),
    .lp_osc_clk(lp), .regulator_level(lvl), .irq(irq));
  rpm_radio_model rad (.pclk(pclk), .presetn(presetn), .push(push),
    .pop(pop), .brown(brown), .fifo_flush(flush), .regulator_level(lvl),
    .fifo_empty(f_empty), .regulator_ok(reg_ok), .supply_low(s_low));
  //////////////////////////////////////////////////////////////////////////
  // Clock, verdict and watchdog
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic complete_run;
    if (mismatches == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #300us;
    mismatches++;
    complete_run;
  end
  //////////////////////////////////////////////////////////////////////////
  // Bus master; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Poll the applied mode; bounded so a stuck sequencer shows up
  task automatic wait_act(input logic [3:0] code);
    for (int i = 0; i < 40; i++)
    begin
      apb(1'b0, OFS_ACTIVE, 32'h0);
      if (rdat[3:0] === code)
        break;
    end
    `CHK("active", code, rdat[3:0])
  endtask
  task automatic t_reset;
    `CHK("miso_rst", 1'b0, miso)
    repeat (20) @(posedge pclk);
    `CHK("miso_up", 1'b1, miso)
    apb(1'b0, OFS_MODE, 32'h0);
    `CHK("mode_rst", 32'h0, rdat)
  endtask
  // Every defined code except full-off; transmit only after its settle mode
  task automatic t_modes;
    logic [3:0] c[8];
    logic [6:0] x[8];
    int hi;
    c = '{MODE_FIFO_ONLY, MODE_SYNTH_RX, MODE_RX_ACTIVE, MODE_SYNTH_TX,
      MODE_TX_ACTIVE, MODE_STANDBY, MODE_WOR, MODE_CORE_OFF};
    x = '{7'h02, 7'h43, 7'h63, 7'h4B, 7'h5B, 7'h06, 7'h05, 7'h05};
    foreach (c[i])
    begin
      apb(1'b1, OFS_MODE, {28'h0, c[i]});
      wait_act(c[i]);
      `CHK("sections", x[i][6:3], {synth, rx, tx, txf})
      `CHK("supply", x[i][2:0], {flush, lvl})
      // Oscillator must be both high and low inside the window
      hi = 0;
      repeat (20)
      begin
        @(posedge pclk);
        hi += int'(lp);
      end
      `CHK("lp_osc", c[i] == MODE_WOR, hi > 0 && hi < 20)
    end
  endtask
  // Core-off and standby wait for the FIFO to drain
  task automatic t_defer;
    logic [3:0] c[2];
    c = '{MODE_CORE_OFF, MODE_STANDBY};
    foreach (c[i])
    begin
      apb(1'b1, OFS_MODE, {28'h0, MODE_FIFO_ONLY});
      wait_act(MODE_FIFO_ONLY);
      push <= 1'b1;
      @(posedge pclk);
      push <= 1'b0;
      apb(1'b1, OFS_MODE, {28'h0, c[i]});
      repeat (30) @(posedge pclk);
      apb(1'b0, OFS_ACTIVE, 32'h0);
      `CHK("deferred", MODE_FIFO_ONLY, rdat[3:0])
      pop <= 1'b1;
      @(posedge pclk);
      pop <= 1'b0;
      wait_act(c[i]);
    end
  endtask
  // Reserved codes dropped; unmapped address refused
  task automatic t_reserved;
    logic [3:0] c[7];
    c = '{4'h2, 4'h3, 4'h4, 4'h7, 4'hA, 4'hE, 4'hF};
    foreach (c[i])
      apb(1'b1, OFS_MODE, {28'h0, c[i]});
    apb(1'b0, OFS_MODE, 32'h0);
    `CHK("reserved", {28'h0, MODE_STANDBY}, rdat)
    apb(1'b0, 8'h14, 32'h0);
    `CHK("unmapped", 1'b1, rerr)
  endtask
  // Brown-out status, masked and unmasked interrupt, one-to-clear
  task automatic t_irq;
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    brown <= 1'b1;
    repeat (5) @(posedge pclk);
    apb(1'b0, OFS_POWSTAT, 32'h0);
    `CHK("powstat", 32'h3, rdat)
    `CHK("irq_mask", 1'b0, irq)
    apb(1'b1, OFS_IRQ_MASK, 32'h2);
    repeat (2) @(posedge pclk);
    `CHK("irq_on", 1'b1, irq)
    brown <= 1'b0;
    repeat (5) @(posedge pclk);
    apb(1'b1, OFS_IRQ_STAT, 32'h2);
    repeat (2) @(posedge pclk);
    `CHK("irq_clr", 1'b0, irq)
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    `CHK("irq_stat", 32'hD, rdat)
  endtask
  // Full-off stays down until the enable line is pulled low
  task automatic t_full_off;
    apb(1'b1, OFS_MODE, {28'h0, MODE_FULL_OFF});
    repeat (20) @(posedge pclk);
    `CHK("off_miso", 1'b0, miso)
    `CHK("off_en", 5'h0, {synth, rx, tx, fifo_acc, core_en})
    en_n <= 1'b0;
    repeat (20) @(posedge pclk);
    `CHK("wake_miso", 1'b1, miso)
    en_n <= 1'b1;
    apb(1'b0, OFS_MODE, 32'h0);
    `CHK("regs_lost", 32'h0, rdat)
    apb(1'b0, OFS_IRQ_MASK, 32'h0);
    `CHK("mask_lost", 32'h0, rdat)
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {psel, penable, pwrite, push, pop, brown, presetn} = 7'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    en_n = 1'b1;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_modes;
    t_defer;
    t_reserved;
    t_irq;
    t_full_off;
    complete_run;
  end
endmodule // test_rpm_ctrl
`default_nettype wire
